// File: bench/dmid_checker.sv
`timescale 1ns/10ps
`default_nettype none
module dmid_checker #(
   parameter int XSTB_CYC = 3
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // Watched ports
   input  wire logic        code_req_o,
   input  wire logic [15:0] code_addr_o,
   input  wire logic        code_ack_i,
   input  wire logic [7:0]  lad_port_out_o,
   input  wire logic        lad_port_oe_o,
   input  wire logic [7:0]  high_address_port_o,
   input  wire logic        ale_o,
   input  wire logic        rd_n_o,
   input  wire logic        wr_n_o,
   input  wire logic [7:0]  acc_o,
   input  wire logic        instr_done_o
);
   logic       strb;
   logic [7:0] cnt_r;
   assign strb = !(rd_n_o && wr_n_o);
   // Counts strobe cycles of the current access
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) cnt_r <= 8'h00;
      else cnt_r <= strb ? cnt_r + 8'h01 : 8'h00;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_addr_phase;
      ale_o && lad_port_oe_o;
   endsequence
   sequence s_strobe_end;
      $fell(strb);
   endsequence
   a_ale_pulse: assert property (ale_o |=> !ale_o)
      else $error("address strobe longer than one cycle");
   a_addr_strobe: assert property (s_addr_phase |=> strb)
      else $error("no strobe after address phase");
   a_strobe_excl: assert property (rd_n_o || wr_n_o)
      else $error("read and write strobes together");
   a_read_float: assert property (!rd_n_o |-> !lad_port_oe_o)
      else $error("low port driven during read");
   a_write_data: assert property (!wr_n_o |-> lad_port_oe_o
      && lad_port_out_o == acc_o)
      else $error("write data is not the accumulator");
   a_strobe_len: assert property (s_strobe_end
      |-> cnt_r == 8'(XSTB_CYC))
      else $error("strobe length wrong");
   a_hport_hold: assert property (strb
      |-> $stable(high_address_port_o))
      else $error("high port moved during access");
   a_done_xfer: assert property (s_strobe_end |-> instr_done_o)
      else $error("no completion at end of access");
   a_req_hold: assert property (code_req_o && !code_ack_i
      |=> code_req_o && $stable(code_addr_o))
      else $error("program request dropped or moved");
   a_done_pulse: assert property (instr_done_o
      |=> !instr_done_o)
      else $error("completion longer than one cycle");
endmodule : dmid_checker
bind dmid_core dmid_checker #(.XSTB_CYC(XSTB_CYC)) chk_u (.clk_i, .rstn_i,
   .code_req_o, .code_addr_o, .code_ack_i, .lad_port_out_o, .lad_port_oe_o,
   .high_address_port_o, .ale_o, .rd_n_o, .wr_n_o, .acc_o, .instr_done_o);
`default_nettype wire

// File: bench/dmid_core_test.sv
`timescale 1ns/10ps
`default_nettype none
module dmid_core_test;
   typedef struct {
      logic [23:0] code;
      int          n;
      logic [7:0]  acc;
      logic [15:0] dp;
      logic        cy;
   } dmid_row_t;
   localparam int NROW = 30;
   dmid_row_t rows [NROW] = '{
      '{24'h74_5A00, 2, 8'h5A, 16'h0000, 0},
      '{24'h90_1234, 3, 8'h5A, 16'h1234, 0},
      '{24'hF5_3000, 2, 8'h5A, 16'h1234, 0},
      '{24'h74_0000, 2, 8'h00, 16'h1234, 0},
      '{24'hE5_3000, 2, 8'h5A, 16'h1234, 0},
      '{24'h85_3031, 3, 8'h5A, 16'h1234, 0},
      '{24'h74_0000, 2, 8'h00, 16'h1234, 0},
      '{24'hE5_3100, 2, 8'h5A, 16'h1234, 0},
      '{24'hAA_3100, 2, 8'h5A, 16'h1234, 0},
      '{24'h74_0000, 2, 8'h00, 16'h1234, 0},
      '{24'hE5_0200, 2, 8'h5A, 16'h1234, 0},
      '{24'h74_F000, 2, 8'hF0, 16'h1234, 0},
      '{24'h93_0000, 1, 8'h6B, 16'h1234, 0},
      '{24'h74_FE00, 2, 8'hFE, 16'h1234, 0},
      '{24'h83_0000, 1, 8'h41, 16'h1234, 0},
      '{24'h00_0000, 1, 8'h41, 16'h1234, 0},
      '{24'h74_8100, 2, 8'h81, 16'h1234, 0},
      '{24'hA2_E700, 2, 8'h81, 16'h1234, 1},
      '{24'h92_E100, 2, 8'h83, 16'h1234, 1},
      // Software puts the upper address bits on the high port latch
      '{24'h75_A012, 3, 8'h83, 16'h1234, 1},
      '{24'h90_ABCD, 3, 8'h83, 16'hABCD, 1},
      '{24'h74_7700, 2, 8'h77, 16'hABCD, 1},
      '{24'hF0_0000, 1, 8'h77, 16'hABCD, 1},
      '{24'h74_0000, 2, 8'h00, 16'hABCD, 1},
      '{24'hE0_0000, 1, 8'h77, 16'hABCD, 1},
      '{24'h79_C500, 2, 8'h77, 16'hABCD, 1},
      '{24'hF3_0000, 1, 8'h77, 16'hABCD, 1},
      '{24'h74_0000, 2, 8'h00, 16'hABCD, 1},
      '{24'hE3_0000, 1, 8'h77, 16'hABCD, 1},
      '{24'hE2_0000, 1, 8'h3C, 16'hABCD, 1}};
   logic        clk_i, rstn_i, slow, code_req_o, code_ack_i, lad_port_oe_o;
   logic        ale_o, rd_n_o, wr_n_o, carry_o, instr_done_o, illegal_o;
   logic [15:0] code_addr_o, data_pointer_o, pc_o, pcx;
   logic [7:0]  code_data_i, lad_port_in_i, lad_port_out_o;
   logic [7:0]  high_address_port_o, acc_o;
   int          error_cnt = 0;
   int          total_checks = 0;
   dmid_core #(.XSTB_CYC(3)) dut_u (.clk_i, .rstn_i, .code_req_o,
      .code_addr_o, .code_ack_i, .code_data_i, .lad_port_in_i, .lad_port_out_o,
      .lad_port_oe_o, .high_address_port_o, .ale_o, .rd_n_o, .wr_n_o, .acc_o,
      .carry_o, .data_pointer_o, .pc_o, .instr_done_o, .illegal_o);
   dmid_mem_model mem_u (.clk_i, .slow_i(slow), .code_req_i(code_req_o),
      .code_addr_i(code_addr_o), .code_ack_o(code_ack_i),
      .code_data_o(code_data_i), .lad_out_i(lad_port_out_o),
      .lad_oe_i(lad_port_oe_o), .hport_i(high_address_port_o), .ale_i(ale_o),
      .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .lad_in_o(lad_port_in_i));
   always #10 clk_i = ~clk_i;
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic wait_done();
      int t;
      t = 0;
      do begin
         @(posedge clk_i);
         #1 t++;
      end while (instr_done_o !== 1'b1 && t < 60);
      if (t >= 60) begin
         error_cnt++;
         $display("MISMATCH at %0t: no completion", $time);
         give_verdict();
      end
   endtask : wait_done
   initial begin
      clk_i = 1'b0;
      rstn_i = 1'b0;
      slow = 1'b0;
      pcx = 16'h0000;
      // Program goes in after the memory model has filled its arrays
      #1;
      for (int i = 0; i < NROW; i++) begin
         for (int k = 0; k < rows[i].n; k++) begin
            mem_u.rom[pcx] = rows[i].code[23-8*k -: 8];
            pcx++;
         end
      end
      repeat (12) @(posedge clk_i);
      #2 rstn_i = 1'b1;
      pcx = 16'h0000;
      for (int i = 0; i < NROW; i++) begin
         pcx += 16'(rows[i].n);
         wait_done();
         check(acc_o, rows[i].acc);
         check(data_pointer_o, rows[i].dp);
         check(carry_o, rows[i].cy);
         check(illegal_o, rows[i].code[23:16] == 8'h00);
         check(pc_o, pcx);
         #1 slow = 1'(i % 2);
      end
      check(mem_u.xram[16'hABCD], 8'h77);
      check(mem_u.xram[16'h12C5], 8'h77);
      check(high_address_port_o, 8'h12);
      $display("test table done");
      rstn_i = 1'b0;
      #1 check({code_req_o, code_addr_o, acc_o, data_pointer_o, rd_n_o,
         wr_n_o, ale_o, lad_port_oe_o}, {1'b1, 40'h00_0000_0000, 4'hC});
      repeat (2) @(posedge clk_i);
      #2 rstn_i = 1'b1;
      wait_done();
      check(acc_o, 8'h5A);
      $display("test reset done");
      give_verdict();
   end
endmodule : dmid_core_test
`default_nettype wire

// File: bench/dmid_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module dmid_mem_model (
   // Clock and pacing
   input  wire logic        clk_i,
   input  wire logic        slow_i,
   // Program memory
   input  wire logic        code_req_i,
   input  wire logic [15:0] code_addr_i,
   output logic             code_ack_o,
   output logic [7:0]       code_data_o,
   // External bus
   input  wire logic [7:0]  lad_out_i,
   input  wire logic        lad_oe_i,
   input  wire logic [7:0]  hport_i,
   input  wire logic        ale_i,
   input  wire logic        rd_n_i,
   input  wire logic        wr_n_i,
   output logic [7:0]       lad_in_o
);
   logic [7:0]  rom [0:65535];
   logic [7:0]  xram [0:65535];
   logic [15:0] xaddr_r = 16'h0000;
   logic [1:0]  wait_r = 2'h0;
   logic [7:0]  last_r = 8'h00;
   initial begin
      for (int i = 0; i < 65536; i++) begin
         rom[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5C;
         xram[i] = 8'h3C;
      end
   end
   // Answers at once, or after two stalled cycles when slow
   assign code_ack_o = code_req_i && (!slow_i || wait_r == 2'h2);
   assign code_data_o = code_ack_o ? rom[code_addr_i] : ~rom[code_addr_i];
   // Released low port shows memory data while read strobe is low, else a pattern that changes every cycle
   assign lad_in_o = lad_oe_i ? lad_out_i : (!rd_n_i ? xram[xaddr_r] : ~last_r);
   always @(posedge clk_i) begin
      wait_r <= (code_req_i && !code_ack_o) ? wait_r + 2'h1 : 2'h0;
      if (ale_i) xaddr_r <= {hport_i, lad_out_i};
      if (!wr_n_i && lad_oe_i) xram[xaddr_r] <= lad_out_i;
      last_r <= lad_in_o;
   end
endmodule : dmid_mem_model
`default_nettype wire

// File: design/dmid_core.sv
// Functional notes
// - Bit move copies between carry and any directly addressable bit.
// - Bit move changes only the destination bit.
// - Pointer load: byte two to high byte, byte three to low byte.
// - Pointer load is the only sixteen-bit move; flags untouched.
// - Code-byte read loads accumulator from program memory.
// - Code-byte address is accumulator plus pointer or program counter.
// - Program counter base is advanced first; pointer base unchanged.
// - Code-byte address is a full 16-bit sum; no flags changed.
// - External move transfers one accumulator byte, 8 or 16-bit address.
// - Short form takes address from bank index register on low port.
// - Long form: high byte on high port, low byte muxed on low port.
// - High port latch keeps its contents during long-form access.
// - Long form reaches 64 Kbyte with no port setup.
// - Direct into banked register uses 10101rrr plus direct byte.
// - Direct-to-direct carries source byte before destination; 3 bytes.
// - Byte moves copy source to destination, nothing else changes.
`timescale 1ns/10ps
`default_nettype none
module dmid_core
   import dmid_pkg::*;
#(
   parameter int XSTB_CYC = `DMID_XSTB_CYC
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // Program memory
   output logic             code_req_o,
   output logic [15:0]      code_addr_o,
   input  wire logic        code_ack_i,
   input  wire logic [7:0]  code_data_i,
   // External bus pins
   input  wire logic [7:0]  lad_port_in_i,
   output logic [7:0]       lad_port_out_o,
   output logic             lad_port_oe_o,
   output logic [7:0]       high_address_port_o,
   output logic             ale_o,
   output logic             rd_n_o,
   output logic             wr_n_o,
   // Core state
   output logic [7:0]       acc_o,
   output logic             carry_o,
   output logic [15:0]      data_pointer_o,
   output logic [15:0]      pc_o,
   output logic             instr_done_o,
   output logic             illegal_o
);
   logic [7:0]  mem_r [256];
   dmid_state_t state_r, state_nxt;
   logic [15:0] pc_r, code_ptr_r, code_ptr_nxt;
   logic [7:0]  op_r, b1_r, b2_r;
   logic [1:0]  len_r;
   logic [7:0]  xlow_r, xlow_nxt, xhigh_r, xhigh_nxt;
   logic        xwide_nxt;
   logic [7:0]  sync1_r, sync2_r;
   logic [7:0]  xcnt_r;
   logic        we, dp_we, illegal;
   logic [7:0]  wa, wd;
   logic [7:0]  acc, psw, pointer_low_byte, pointer_high_byte, rn_a, ri_a, ri_v, bit_a;
   logic [2:0]  bit_i;
   logic        bit_v;

   assign acc   = mem_r[`DMID_ADDR_ACC];
   assign psw   = mem_r[`DMID_ADDR_PSW];
   assign pointer_low_byte   = mem_r[`DMID_ADDR_PTR_LO];
   assign pointer_high_byte   = mem_r[`DMID_ADDR_PTR_HI];
   assign rn_a  = {3'b000, psw[`DMID_PSW_BANK_HI:`DMID_PSW_BANK_LO], op_r[2:0]};
   assign ri_a  = {3'b000, psw[`DMID_PSW_BANK_HI:`DMID_PSW_BANK_LO], 2'b00,
                   op_r[0]};
   assign ri_v  = mem_r[ri_a];
   // Bit space: low half maps to RAM bytes, high half to byte-aligned SFRs
   assign bit_a = b1_r[7] ? {b1_r[7:3], 3'b000}
                          : (`DMID_BIT_RAM_BASE + {4'h0, b1_r[6:3]});
   assign bit_i = b1_r[2:0];
   assign bit_v = mem_r[bit_a][bit_i];

   assign code_req_o = (state_r == S_FETCH) || (state_r == S_OPR1) ||
                       (state_r == S_OPR2) || (state_r == S_CODE);
   assign code_addr_o = (state_r == S_CODE) ? code_ptr_r : pc_r;
   assign acc_o = acc;
   assign carry_o = psw[`DMID_PSW_CY];
   assign data_pointer_o = {pointer_high_byte, pointer_low_byte};
   assign pc_o = pc_r;

   // Execute decode
   always_comb begin
      we = 1'b0;
      dp_we = 1'b0;
      illegal = 1'b0;
      wa = `DMID_ADDR_ACC;
      wd = 8'h00;
      code_ptr_nxt = code_ptr_r;
      xlow_nxt = xlow_r;
      xhigh_nxt = xhigh_r;
      xwide_nxt = 1'b0;
      state_nxt = S_FETCH;
      unique casez (op_r)
         8'b1110_1???:   begin we = 1'b1; wd = mem_r[rn_a]; end
         `DMID_OP_A_DIR: begin we = 1'b1; wd = mem_r[b1_r]; end
         8'b1110_011?:   begin we = 1'b1; wd = mem_r[ri_v]; end
         `DMID_OP_A_IMM: begin we = 1'b1; wd = b1_r; end
         8'b1111_1???:   begin we = 1'b1; wa = rn_a; wd = acc; end
         8'b1010_1???:   begin
            we = 1'b1;
            wa = rn_a;
            wd = mem_r[b1_r];
         end
         8'b0111_1???:   begin we = 1'b1; wa = rn_a; wd = b1_r; end
         `DMID_OP_DIR_A: begin we = 1'b1; wa = b1_r; wd = acc; end
         8'b1000_1???:   begin we = 1'b1; wa = b1_r; wd = mem_r[rn_a]; end
         `DMID_OP_DIR_DIR: begin
            we = 1'b1;
            wa = b2_r;
            wd = mem_r[b1_r];
         end
         8'b1000_011?:   begin we = 1'b1; wa = b1_r; wd = mem_r[ri_v]; end
         `DMID_OP_DIR_IMM: begin we = 1'b1; wa = b1_r; wd = b2_r; end
         8'b1111_011?:   begin we = 1'b1; wa = ri_v; wd = acc; end
         8'b1010_011?:   begin we = 1'b1; wa = ri_v; wd = mem_r[b1_r]; end
         8'b0111_011?:   begin we = 1'b1; wa = ri_v; wd = b1_r; end
         `DMID_OP_C_BIT: begin
            we = 1'b1;
            wa = `DMID_ADDR_PSW;
            wd = psw;
            wd[`DMID_PSW_CY] = bit_v;
         end
         `DMID_OP_BIT_C: begin
            we = 1'b1;
            wa = bit_a;
            wd = mem_r[bit_a];
            wd[bit_i] = psw[`DMID_PSW_CY];
         end
         `DMID_OP_PTR_IMM: dp_we = 1'b1;
         `DMID_OP_CODE_PTR: begin
            code_ptr_nxt = {pointer_high_byte, pointer_low_byte} + {8'h00, acc};
            state_nxt = S_CODE;
         end
         `DMID_OP_CODE_PC: begin
            code_ptr_nxt = pc_r + {8'h00, acc};
            state_nxt = S_CODE;
         end
         `DMID_OP_XRD_PTR, `DMID_OP_XWR_PTR,
         8'b1110_001?, 8'b1111_001?: begin
            xwide_nxt = ~op_r[1];
            xlow_nxt = xwide_nxt ? pointer_low_byte : ri_v;
            xhigh_nxt = xwide_nxt ? pointer_high_byte : mem_r[`DMID_ADDR_HPORT];
            state_nxt = S_XADDR;
         end
         default: illegal = 1'b1;
      endcase
   end

   // Sequencer
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_r <= S_FETCH;
         pc_r <= 16'h0000;
         op_r <= 8'h00;
         b1_r <= 8'h00;
         b2_r <= 8'h00;
         len_r <= 2'd1;
         code_ptr_r <= 16'h0000;
         xlow_r <= 8'h00;
         xhigh_r <= 8'h00;
         xcnt_r <= 8'h00;
      end else begin
         unique case (state_r)
            S_FETCH: if (code_ack_i) begin
               op_r <= code_data_i;
               len_r <= dmid_len(code_data_i);
               pc_r <= pc_r + 16'h0001;
               state_r <= (dmid_len(code_data_i) == 2'd1) ? S_EXEC : S_OPR1;
            end
            S_OPR1: if (code_ack_i) begin
               b1_r <= code_data_i;
               pc_r <= pc_r + 16'h0001;
               state_r <= (len_r == 2'd3) ? S_OPR2 : S_EXEC;
            end
            S_OPR2: if (code_ack_i) begin
               b2_r <= code_data_i;
               pc_r <= pc_r + 16'h0001;
               state_r <= S_EXEC;
            end
            S_EXEC: begin
               code_ptr_r <= code_ptr_nxt;
               xlow_r <= xlow_nxt;
               xhigh_r <= xhigh_nxt;
               xcnt_r <= 8'h00;
               state_r <= state_nxt;
            end
            S_CODE: if (code_ack_i) state_r <= S_FETCH;
            S_XADDR: state_r <= op_r[4] ? S_XWR : S_XRD;
            S_XRD, S_XWR: begin
               xcnt_r <= xcnt_r + 8'h01;
               if (xcnt_r == 8'(XSTB_CYC - 1)) state_r <= S_FETCH;
            end
         endcase
      end
   end

   // Internal data space; SFRs included
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int k = 0; k < 256; k++) mem_r[k] <= 8'h00;
      end else begin
         if (state_r == S_EXEC && we) mem_r[wa] <= wd;
         if (state_r == S_EXEC && dp_we) begin
            mem_r[`DMID_ADDR_PTR_HI] <= b1_r;
            mem_r[`DMID_ADDR_PTR_LO] <= b2_r;
         end
         if (state_r == S_CODE && code_ack_i)
            mem_r[`DMID_ADDR_ACC] <= code_data_i;
         if (state_r == S_XRD && xcnt_r == 8'(XSTB_CYC - 1))
            mem_r[`DMID_ADDR_ACC] <= sync2_r;
      end
   end

   // Pin input synchroniser
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1_r <= 8'h00;
         sync2_r <= 8'h00;
      end else begin
         sync1_r <= lad_port_in_i;
         sync2_r <= sync1_r;
      end
   end

   // Registered bus pins and status pulses
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lad_port_out_o <= 8'h00;
         lad_port_oe_o <= 1'b0;
         high_address_port_o <= 8'h00;
         ale_o <= 1'b0;
         rd_n_o <= 1'b1;
         wr_n_o <= 1'b1;
         instr_done_o <= 1'b0;
         illegal_o <= 1'b0;
      end else begin
         ale_o <= (state_r == S_EXEC) && (state_nxt == S_XADDR);
         rd_n_o <= !((state_r == S_XADDR && !op_r[4]) ||
                     (state_r == S_XRD && xcnt_r != 8'(XSTB_CYC - 1)));
         wr_n_o <= !((state_r == S_XADDR && op_r[4]) ||
                     (state_r == S_XWR && xcnt_r != 8'(XSTB_CYC - 1)));
         if (state_r == S_EXEC && state_nxt == S_XADDR) begin
            lad_port_out_o <= xlow_nxt;
            lad_port_oe_o <= 1'b1;
            high_address_port_o <= xhigh_nxt;
         end else if (state_r == S_XADDR) begin
            lad_port_out_o <= acc;
            lad_port_oe_o <= op_r[4];
         end else if (state_r == S_XRD || state_r == S_XWR) begin
            lad_port_oe_o <= op_r[4] && (xcnt_r != 8'(XSTB_CYC - 1));
         end else begin
            lad_port_oe_o <= 1'b0;
            high_address_port_o <= mem_r[`DMID_ADDR_HPORT];
         end
         instr_done_o <= (state_r == S_EXEC && state_nxt == S_FETCH) ||
                         (state_r == S_CODE && code_ack_i) ||
                         ((state_r == S_XRD || state_r == S_XWR) &&
                          xcnt_r == 8'(XSTB_CYC - 1));
         illegal_o <= (state_r == S_EXEC) && illegal;
      end
   end
endmodule : dmid_core
`default_nettype wire

// File: design/dmid_pkg.sv
`include "dmid_regs.svh"
package dmid_pkg;
   typedef enum logic [2:0] {
      S_FETCH = 3'b000,
      S_OPR1  = 3'b001,
      S_OPR2  = 3'b010,
      S_EXEC  = 3'b011,
      S_CODE  = 3'b100,
      S_XADDR = 3'b101,
      S_XRD   = 3'b110,
      S_XWR   = 3'b111
   } dmid_state_t;

   // Instruction length in bytes
   function automatic logic [1:0] dmid_len(input logic [7:0] op);
      logic [1:0] n;
      n = 2'd1;
      casez (op)
         `DMID_OP_DIR_DIR, `DMID_OP_DIR_IMM, `DMID_OP_PTR_IMM: n = 2'd3;
         `DMID_OP_A_DIR, `DMID_OP_A_IMM, `DMID_OP_DIR_A,
         `DMID_OP_C_BIT, `DMID_OP_BIT_C,
         8'b1010_1???, 8'b0111_1???, 8'b1000_1???,
         8'b1000_011?, 8'b1010_011?, 8'b0111_011?: n = 2'd2;
         default: n = 2'd1;
      endcase
      return n;
   endfunction : dmid_len
endpackage : dmid_pkg

// File: design/dmid_regs.svh
`ifndef DMID_REGS_SVH
`define DMID_REGS_SVH
// Special function byte addresses inside the direct space
`define DMID_ADDR_ACC       8'hE0
`define DMID_ADDR_PSW       8'hD0
`define DMID_ADDR_PTR_LO    8'h82
`define DMID_ADDR_PTR_HI    8'h83
`define DMID_ADDR_HPORT     8'hA0
// Status word fields
`define DMID_PSW_CY         7
`define DMID_PSW_BANK_HI    4
`define DMID_PSW_BANK_LO    3
// Bit address space
`define DMID_BIT_RAM_BASE   8'h20
// Opcodes
`define DMID_OP_A_DIR       8'hE5
`define DMID_OP_A_IMM       8'h74
`define DMID_OP_DIR_A       8'hF5
`define DMID_OP_DIR_DIR     8'h85
`define DMID_OP_DIR_IMM     8'h75
`define DMID_OP_C_BIT       8'hA2
`define DMID_OP_BIT_C       8'h92
`define DMID_OP_PTR_IMM     8'h90
`define DMID_OP_CODE_PTR    8'h93
`define DMID_OP_CODE_PC     8'h83
`define DMID_OP_XRD_PTR     8'hE0
`define DMID_OP_XWR_PTR     8'hF0
// Timing
`define DMID_CLK_PERIOD_NS  20
`define DMID_XSTB_NS        60
`define DMID_XSTB_CYC       ((`DMID_XSTB_NS + `DMID_CLK_PERIOD_NS - 1) / `DMID_CLK_PERIOD_NS)
`endif
